//--- ufb_data_master.sv
/*
 * Data port master model: raises one read command per go pulse.
 * Assumes the same clock as the read path and that go is a one-cycle pulse.
 */
`timescale 1ns/10ps
module ufb_data_master #(
	parameter int unsigned AW  = 8,
	parameter int unsigned BCW = 2
) (
	input  wire logic           mclk_i,
	input  wire logic           rst_i,
	input  wire logic           go_i,
	input  wire logic [AW-1:0]  addr_i,
	input  wire logic [BCW-1:0] burst_i,
	input  wire logic           data_wait_i,
	output logic                data_read_o,
	output logic [AW-1:0]       data_addr_o,
	output logic [BCW-1:0]      data_burst_o
);
	// The command is held until an edge samples the stall low, then released.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			data_read_o  <= 1'b0;
			data_addr_o  <= '0;
			data_burst_o <= '0;
		end else if (data_read_o && !data_wait_i) begin
			// Released lines turn to the inverse so no stale value passes for a match.
			data_read_o  <= 1'b0;
			data_addr_o  <= ~data_addr_o;
			data_burst_o <= ~data_burst_o;
		end else if (go_i && !data_read_o) begin
			data_read_o  <= 1'b1;
			data_addr_o  <= addr_i;
			data_burst_o <= burst_i;
		end
	end
endmodule

//--- ufb_flash_store.sv
/*
 * Flip-flop storage standing in for the flash array, with page erase.
 * Assumes the caller only erases while no read is in flight.
 */
`timescale 1ns/10ps
module ufb_flash_store #(
	parameter int unsigned DEPTH      = 160,
	parameter int unsigned AW         = 8,
	parameter int unsigned PAGE_WORDS = 8,
	parameter int unsigned INIT_LEN   = 0,
	parameter logic [32*((INIT_LEN > 0) ? INIT_LEN : 1)-1:0] INIT_IMAGE = '1
) (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_i,
	input  wire logic [AW-1:0]        rd_addr_i,
	output logic [ufb_pkg::WORD_W-1:0] rd_data_o,
	input  wire logic                 erase_i,
	input  wire logic [AW-1:0]        erase_addr_i
);
	import ufb_pkg::*;

	logic [WORD_W-1:0] mem_q [DEPTH];   // Array contents.
	logic [AW-1:0]     page_base;       // First word of the page being erased.

	// Pages are aligned groups, so the base is the address with its low bits cleared.
	assign page_base = AW'((erase_addr_i / AW'(PAGE_WORDS)) * AW'(PAGE_WORDS));

	// Reset stands in for power-up: image words load, the rest read erased.
	// Image words past the array size have no slot and are dropped.
	always_ff @(posedge mclk_i) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (rst_i) begin
				mem_q[i] <= (i < INIT_LEN) ? INIT_IMAGE[i*32 +: 32] : WORD_ERASED;
			end else if (erase_i && (i >= page_base) && (i < page_base + PAGE_WORDS)) begin
				mem_q[i] <= WORD_ERASED;
			end
		end
	end

	// Asynchronous read; the caller registers the result.
	assign rd_data_o = (rd_addr_i < AW'(DEPTH)) ? mem_q[rd_addr_i] : WORD_ERASED;

endmodule

//--- ufb_pkg.sv
/*
 * Shared constants, field layouts and types for the user flash read path.
 * Assumes one synchronous clock domain and a 32-bit register bus.
 */
package ufb_pkg;

	// Width of one flash word and of the register bus.
	localparam int unsigned WORD_W       = 32;
	// Bits shifted out per word in serial mode.
	localparam int unsigned SERIAL_BITS  = 32;
	// Number of sectors: two user sectors and three configuration sectors.
	localparam int unsigned SECTORS      = 5;

	// Register indices and their byte addresses (index times four).
	localparam logic [11:0] REG_STATUS_IDX = 12'h000;
	localparam logic [11:0] REG_CTRL_IDX   = 12'h001;
	localparam logic [11:0] ADDR_STATUS    = 12'(REG_STATUS_IDX << 2);
	localparam logic [11:0] ADDR_CTRL      = 12'(REG_CTRL_IDX << 2);

	// Busy codes of the status word.
	localparam logic [1:0]  BUSY_IDLE      = 2'h0;
	localparam logic [1:0]  BUSY_ERASE     = 2'h1;
	localparam logic [1:0]  BUSY_WRITE     = 2'h2;
	localparam logic [1:0]  BUSY_READ      = 2'h3;

	// Reset values and special codes.
	localparam logic [31:0] WORD_ERASED    = 32'hffffffff;
	localparam logic [19:0] PE_NONE        = 20'hfffff;
	localparam logic [2:0]  SE_RESET       = 3'h7;
	localparam logic [4:0]  WP_RESET       = 5'h1f;
	localparam logic [21:0] STAT_PAD       = 22'h3fffff;
	localparam logic [3:0]  CTRL_PAD       = 4'hf;

	// Configuration modes that decide which configuration sectors act as user flash.
	localparam int unsigned CFG_DUAL          = 0;
	localparam int unsigned CFG_SINGLE_UNCOMP = 1;
	localparam int unsigned CFG_SINGLE_COMP   = 2;

	// Sector slots; also the bit order of the protection fields.
	localparam int unsigned SEC_USER_ONE   = 0;
	localparam int unsigned SEC_USER_ZERO  = 1;
	localparam int unsigned SEC_CFG_THREE  = 2;
	localparam int unsigned SEC_CFG_TWO    = 3;

	// Read-only status word.
	typedef struct packed {
		logic [21:0] pad;        // Always ones.
		logic [4:0]  sect_prot;  // One bit per sector, set when it may not be touched.
		logic        erase_ok;   // Last erase succeeded.
		logic        write_ok;   // Last program succeeded.
		logic        read_ok;    // Last read succeeded.
		logic [1:0]  busy;       // Busy code.
	} ufb_status_t;

	// Control word.
	typedef struct packed {
		logic [3:0]  pad;        // Always ones.
		logic [4:0]  wprot;      // Write protection, one bit per sector.
		logic [2:0]  sect_addr;  // Sector erase address, stored only.
		logic [19:0] page_addr;  // Page erase address.
	} ufb_ctrl_t;

	// Main sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ERASE = 3'b010,
		ST_READ  = 3'b100
	} ufb_state_t;

endpackage

//--- ufb_read_path.sv
/*
 * User flash read path: burst data port, page erase, status and control over APB.
 * Assumes the data master and the APB master share mclk_i with this block.
 */
// Added by the designer: the APB register port and the address map.
//
// Summary of operation
// - Illegal page erase address clears erase_ok flag.
// - Waitrequest stays high while busy.
// - Each word returned with readdatavalid.
// - Busy code 2'b11 during any read.
// - Read ok set; illegal/protected gives erased data.
// - Incrementing bursts stream words, up to 128.
// - Wrap burst fixed at 2 or 4.
// - Wrapping only in parallel mode.
// - Narrow bus wraps after two beats.
// - Wide bus wraps after four beats.
// - Incrementing burst continues from flash start.
// - Data port parallel or serial, parallel default.
// - Maximum burst is 2, 4, 8 or 128.
// - Serial burst counts words times 32 bits.
// - Smallest variant has no wrapping mode.
// - Configuration mode maps configuration sectors as user.
// - Hidden access only for configuration sectors.
// - Uninitialised words erased; excess init dropped.
// - Read data 32 bits parallel, 1 serial.
// - Status word shows busy code and flags.
//
`timescale 1ns/10ps
module ufb_read_path #(
	parameter bit          SERIAL_MODE  = 1'b0,   // Parallel unless chosen otherwise.
	parameter bit          WRAP_MODE    = 1'b0,   // Incrementing bursts by default.
	parameter bit          WIDE_BUS     = 1'b1,   // Internal flash bus of 128 rather than 64 bits.
	parameter bit          SMALL_PART   = 1'b0,   // Smallest variant.
	parameter int unsigned BURST_MAX    = 2,      // One of 2, 4, 8, 128.
	parameter int unsigned CFG_MODE     = 1,      // Single uncompressed image.
	parameter logic [4:0]  HIDDEN_REQ   = 5'h00,  // Hidden access request per sector.
	parameter int unsigned SECT_WORDS   = 32,
	parameter int unsigned PAGE_WORDS   = 8,
	parameter int unsigned ERASE_CYCLES = 16,
	parameter int unsigned INIT_LEN     = 0,
	parameter logic [32*((INIT_LEN > 0) ? INIT_LEN : 1)-1:0] INIT_IMAGE = '1,
	// Derived shapes; leave at their defaults.
	parameter int unsigned DEPTH = ufb_pkg::SECTORS * SECT_WORDS,
	parameter int unsigned AW    = $clog2(DEPTH),
	parameter int unsigned DW    = SERIAL_MODE ? 1 : ufb_pkg::WORD_W,
	parameter int unsigned BCW   = $clog2((SERIAL_MODE ? ufb_pkg::SERIAL_BITS : 1) * BURST_MAX) + 1
) (
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	input  wire logic          psel_i,
	input  wire logic          penable_i,
	input  wire logic          pwrite_i,
	input  wire logic [11:0]   paddr_i,
	input  wire logic [31:0]   pwdata_i,
	output logic      [31:0]   prdata_o,
	output logic               pready_o,
	output logic               pslverr_o,
	input  wire logic          data_read_i,
	input  wire logic [AW-1:0] data_addr_i,
	input  wire logic [BCW-1:0] data_burst_i,
	output logic               data_wait_o,
	output logic               data_rvalid_o,
	output logic [DW-1:0]      data_rdata_o
);
	import ufb_pkg::*;

	// Wrapping needs the parallel port and is absent on the smallest part.
	localparam bit          WRAP_EN  = WRAP_MODE && !SERIAL_MODE && !SMALL_PART;
	// Beats per wrapping burst follow the internal bus width.
	localparam int unsigned WRAP_LEN = WIDE_BUS ? 4 : 2;
	localparam int unsigned WRAP_B   = $clog2(WRAP_LEN);
	// Largest legal burst count on the port.
	localparam int unsigned BURST_LIM = (SERIAL_MODE ? SERIAL_BITS : 1) * BURST_MAX;
	localparam int unsigned SB       = $clog2(SERIAL_BITS);
	localparam int unsigned ECW      = $clog2(ERASE_CYCLES + 1);

	// Sectors acting as user flash in this configuration mode.
	localparam logic [4:0] USER_MAP =
		(CFG_MODE == CFG_SINGLE_COMP)   ? 5'h0f :
		(CFG_MODE == CFG_SINGLE_UNCOMP) ? 5'h07 : 5'h03;
	// Hidden access is honoured only on configuration sectors.
	localparam logic [4:0] HIDDEN  = HIDDEN_REQ & 5'h1c;
	// Protection seen by software: unmapped or hidden sectors.
	localparam logic [4:0] SECT_PROT = ~USER_MAP | HIDDEN;

	ufb_state_t        state_q;      // Sequencer state.
	ufb_ctrl_t         ctrl_q;       // Control word as software last wrote it.
	logic              read_ok_q;    // Outcome of the last read.
	logic              erase_ok_q;   // Outcome of the last erase.
	logic              wait_q;       // Registered waitrequest.
	logic              rvalid_q;     // Registered readdatavalid.
	logic [DW-1:0]     rdata_q;      // Registered read data.
	logic [AW-1:0]     cur_q;        // Word address of the next beat.
	logic [BCW-1:0]    beats_q;      // Beats still to return.
	logic              bad_q;        // Accumulated failure over the burst.
	logic [SB-1:0]     bit_q;        // Bit position within a serial word.
	logic [WORD_W-1:0] shift_q;      // Serial word being shifted out.
	logic [AW-1:0]     erase_addr_q; // Page being erased.
	logic [ECW-1:0]    erase_cnt_q;  // Erase cycles left.
	logic              erase_go;     // One-cycle page clear strobe.
	logic [31:0]       prdata_q;     // APB read data.
	logic              pready_q;     // APB ready.
	logic              pslverr_q;    // APB error.
	logic [WORD_W-1:0] fl_word;      // Word from the array at cur_q.
	ufb_status_t       status;       // Live status word.
	logic              apb_access;   // Access phase not yet answered.
	logic              ctrl_wr;      // Accepted write to the control word.
	logic              pe_start;     // Page erase accepted.
	logic              rd_start;     // Read command accepted.
	logic              burst_ok;     // Burst count legal for this port.
	logic              beat_ok;      // Current beat reads a legal, open word.
	logic              beat_last;    // Current beat closes the burst.
	logic              word_edge;    // Current beat starts a new word.

	// Sector slot that holds a word address.
	function automatic logic [2:0] sector_of(input logic [AW-1:0] a);
		sector_of = 3'(a / AW'(SECT_WORDS));
	endfunction

	// A word may be read when its sector is mapped as user flash and not hidden.
	function automatic logic addr_open(input logic [AW-1:0] a);
		addr_open = (a < AW'(DEPTH)) && !SECT_PROT[sector_of(a)];
	endfunction

	// Next word address of a burst.
	function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
		logic [AW-1:0] inc;
		inc = (a == AW'(DEPTH - 1)) ? '0 : AW'(a + 1'b1);   // Past the end, back to the start.
		if (WRAP_EN) begin
			// Low bits roll within the aligned group, high bits hold.
			next_addr = {a[AW-1:WRAP_B], inc[WRAP_B-1:0]};
		end else begin
			next_addr = inc;   // Plain incrementing order.
		end
	endfunction

	ufb_flash_store #(
		.DEPTH      (DEPTH),
		.AW         (AW),
		.PAGE_WORDS (PAGE_WORDS),
		.INIT_LEN   (INIT_LEN),
		.INIT_IMAGE (INIT_IMAGE)
	) u_store (
		.mclk_i       (mclk_i),
		.rst_i        (rst_i),
		.rd_addr_i    (cur_q),
		.rd_data_o    (fl_word),
		.erase_i      (erase_go),
		.erase_addr_i (erase_addr_q)
	);

	// Status word is assembled from live state; it is never written.
	always_comb begin
		status.pad       = STAT_PAD;
		status.sect_prot = SECT_PROT;
		status.erase_ok  = erase_ok_q;
		status.write_ok  = 1'b0;   // Programming is not part of this path.
		status.read_ok   = read_ok_q;
		case (state_q)
			ST_ERASE: status.busy = BUSY_ERASE;
			ST_READ:  status.busy = BUSY_READ;   // Any read shows the read code.
			default:  status.busy = BUSY_IDLE;
		endcase
	end

	// Burst legality per mode; a bad count still streams, marked failed.
	always_comb begin
		if (WRAP_EN) begin
			burst_ok = (data_burst_i == BCW'(WRAP_LEN));   // Fixed count.
		end else if (SERIAL_MODE) begin
			// Whole words only, 32 bits each.
			burst_ok = (data_burst_i != '0) && (data_burst_i[SB-1:0] == '0)
				&& (data_burst_i <= BCW'(BURST_LIM));
		end else begin
			burst_ok = (data_burst_i != '0) && (data_burst_i <= BCW'(BURST_LIM));
		end
	end

	// Command decode.
	assign apb_access = psel_i && penable_i && !pready_q;
	assign ctrl_wr    = apb_access && pwrite_i && (paddr_i == ADDR_CTRL);
	// Erase is accepted only while idle; otherwise the address is ignored.
	assign pe_start   = ctrl_wr && (state_q == ST_IDLE)
		&& (pwdata_i[19:0] != PE_NONE) && !rd_start;
	// A read is taken in a cycle where waitrequest is low.
	assign rd_start   = (state_q == ST_IDLE) && !wait_q && data_read_i;
	assign word_edge  = !SERIAL_MODE || (bit_q == '0);
	assign beat_ok    = addr_open(cur_q);
	assign beat_last  = (beats_q == BCW'(1));
	assign erase_go   = (state_q == ST_ERASE) && (erase_cnt_q == ECW'(1));

	// Sequencer: idle, erasing or reading.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (rd_start) begin
						state_q <= ST_READ;
					end else if (pe_start) begin
						state_q <= ST_ERASE;
					end
				end
				ST_ERASE: begin
					if (erase_go) begin
						state_q <= ST_IDLE;
					end
				end
				ST_READ: begin
					if (beat_last) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Waitrequest rises the cycle after a command is taken and falls when idle again.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			wait_q <= 1'b1;   // Held off until reset has settled.
		end else if (rd_start || pe_start) begin
			wait_q <= 1'b1;
		end else if ((state_q == ST_READ && beat_last) || erase_go) begin
			wait_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			wait_q <= 1'b0;
		end
	end

	// Burst bookkeeping: address, beats left and failure tracking.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cur_q   <= '0;
			beats_q <= '0;
			bad_q   <= 1'b0;
			bit_q   <= '0;
		end else if (rd_start) begin
			cur_q   <= data_addr_i;
			// A zero count still answers with one beat so the master is never stranded.
			beats_q <= (data_burst_i == '0) ? BCW'(1) : data_burst_i;
			bad_q   <= !burst_ok;
			bit_q   <= '0;
		end else if (state_q == ST_READ) begin
			beats_q <= BCW'(beats_q - 1'b1);
			if (word_edge && !beat_ok) begin
				bad_q <= 1'b1;
			end
			if (SERIAL_MODE) begin
				bit_q <= SB'(bit_q + 1'b1);
				if (bit_q == SB'(SERIAL_BITS - 1)) begin
					cur_q <= next_addr(cur_q);   // Next word after its last bit.
				end
			end else begin
				cur_q <= next_addr(cur_q);
			end
		end
	end

	// Read data and its valid strobe; closed sectors return erased data.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			shift_q  <= '0;
		end else if (state_q == ST_READ) begin
			rvalid_q <= 1'b1;   // One strobe per beat, nothing more.
			if (SERIAL_MODE) begin
				// Most significant bit first; the word is latched on its first bit.
				if (word_edge) begin
					rdata_q <= DW'((beat_ok ? fl_word[WORD_W-1] : 1'b1));
					shift_q <= (beat_ok ? fl_word : WORD_ERASED) << 1;
				end else begin
					rdata_q <= DW'(shift_q[WORD_W-1]);
					shift_q <= shift_q << 1;
				end
			end else begin
				rdata_q <= DW'(beat_ok ? fl_word : WORD_ERASED);
			end
		end else begin
			rvalid_q <= 1'b0;
		end
	end

	// Read outcome is posted when the last beat leaves.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			read_ok_q <= 1'b0;
		end else if (state_q == ST_READ && beat_last) begin
			read_ok_q <= !bad_q && !(word_edge && !beat_ok);
		end
	end

	// Page erase timing and outcome.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			erase_addr_q <= '0;
			erase_cnt_q  <= '0;
			erase_ok_q   <= 1'b0;
		end else if (pe_start) begin
			// Pages past the array park beyond it, so truncation cannot make them legal.
			erase_addr_q <= (pwdata_i[19:0] < 20'(DEPTH)) ? AW'(pwdata_i[19:0]) : '1;
			erase_cnt_q  <= ECW'(ERASE_CYCLES);
		end else if (state_q == ST_ERASE) begin
			erase_cnt_q <= ECW'(erase_cnt_q - 1'b1);
			if (erase_go) begin
				// An address outside user flash, or a protected sector, reports failure.
				erase_ok_q <= addr_open(erase_addr_q) && !ctrl_q.wprot[sector_of(erase_addr_q)];
			end
		end
	end

	// Control word storage. Software must set write protection back after an erase;
	// this block never sets it on its own.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			ctrl_q.pad       <= CTRL_PAD;
			ctrl_q.wprot     <= WP_RESET;
			ctrl_q.sect_addr <= SE_RESET;
			ctrl_q.page_addr <= PE_NONE;
		end else if (ctrl_wr) begin
			ctrl_q.wprot     <= pwdata_i[27:23];
			ctrl_q.sect_addr <= pwdata_i[22:20];
			ctrl_q.page_addr <= pwdata_i[19:0];
		end
	end

	// APB slave: ready one cycle into the access phase; unknown or read-only
	// targets of a write answer with an error and change nothing.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else if (apb_access) begin
			pready_q  <= 1'b1;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
			if (paddr_i == ADDR_STATUS) begin
				prdata_q  <= status;
				pslverr_q <= pwrite_i;
			end else if (paddr_i == ADDR_CTRL) begin
				prdata_q <= ctrl_q;
			end else begin
				pslverr_q <= 1'b1;
			end
		end else begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Every output comes straight from a flip-flop.
	assign prdata_o      = prdata_q;
	assign pready_o      = pready_q;
	assign pslverr_o     = pslverr_q;
	assign data_wait_o   = wait_q;
	assign data_rvalid_o = rvalid_q;
	assign data_rdata_o  = rdata_q;

endmodule

//--- ufb_read_path_asserts.sv
/*
 * Port checker for the flash read path: data beats, stalls and APB answers.
 * Assumes one clock, rst_i synchronous active high, bound into ufb_read_path.
 */
`timescale 1ns/10ps
module ufb_read_path_asserts
	import ufb_pkg::*;
#(
	parameter int unsigned BCW = 2
) (
	input wire logic           mclk_i,
	input wire logic           rst_i,
	input wire logic           psel_i,
	input wire logic           penable_i,
	input wire logic           pwrite_i,
	input wire logic [11:0]    paddr_i,
	input wire logic [31:0]    prdata_o,
	input wire logic           pready_o,
	input wire logic           pslverr_o,
	input wire logic           data_read_i,
	input wire logic [BCW-1:0] data_burst_i,
	input wire logic           data_wait_o,
	input wire logic           data_rvalid_o
);
	logic         take;     // Data command accepted at this edge.
	logic         apb_take; // APB access entering its answer cycle.
	logic [BCW:0] cnt_q;    // Beats seen since the last take.
	logic [BCW:0] exp_q;    // Beats owed; a zero count still owes one.
	assign take     = data_read_i && !data_wait_o;
	assign apb_take = psel_i && penable_i && !pready_o;
	// Beat bookkeeping, restarted at every take so overlaps cannot hide.
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			exp_q <= '0;
		end else if (take) begin
			cnt_q <= '0;
			exp_q <= (data_burst_i == '0) ? (BCW+1)'(1) : {1'b0, data_burst_i};
		end else if (data_rvalid_o) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (rst_i);
	a_take_stall: assert property (take |=> data_wait_o)
		else $error("stall not raised after a take");
	a_first_beat: assert property (take |-> ##[2:3] data_rvalid_o)
		else $error("first beat late");
	a_beat_gap: assert property (data_rvalid_o && (cnt_q + 1'b1 < exp_q) |=> data_rvalid_o)
		else $error("gap inside a burst");
	a_beat_end: assert property (data_rvalid_o && (cnt_q + 1'b1 == exp_q) |=> !data_rvalid_o)
		else $error("burst ran past its count");
	a_beat_excess: assert property (data_rvalid_o |-> cnt_q < exp_q)
		else $error("beat with nothing owed");
	a_beat_stall: assert property (data_rvalid_o && (cnt_q + 1'b1 < exp_q) |-> data_wait_o)
		else $error("stall dropped mid burst");
	a_busy_read: assert property (apb_take && !pwrite_i && paddr_i == ADDR_STATUS && data_rvalid_o
		&& (cnt_q + 1'b1 < exp_q) |=> prdata_o[1:0] == BUSY_READ)
		else $error("busy code wrong during read");
	a_ro_status: assert property (apb_take && pwrite_i && paddr_i == ADDR_STATUS |=> pslverr_o)
		else $error("status write not refused");
	a_status_ok: assert property (apb_take && !pwrite_i && paddr_i == ADDR_STATUS
		|=> pready_o && !pslverr_o)
		else $error("status read not answered cleanly");
	c_long_burst: cover property (take && data_burst_i == BCW'(8));
	c_busy_read: cover property (apb_take && data_rvalid_o);
	c_refused: cover property (pready_o && pslverr_o);
endmodule
bind ufb_read_path ufb_read_path_asserts #(.BCW(BCW)) u_chk (
	.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .data_read_i(data_read_i), .data_burst_i(data_burst_i),
	.data_wait_o(data_wait_o), .data_rvalid_o(data_rvalid_o)
);

//--- ufb_read_path_tb_top.sv
/*
 * Self-checking bench for the flash read path: bursts, status, erase, APB.
 * Assumes the checker is bound in and the model drives the data port.
 */
`timescale 1ns/10ps
module ufb_read_path_tb_top;
	import ufb_pkg::*;
	localparam int unsigned AW    = 8;
	localparam int unsigned BCW   = 4;
	localparam int unsigned DEPTH = 160;
	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] burst;
		logic       ok;
		logic       chk;
	} ufb_row_t;
	// Words 0..7 hold a marked pattern so beat order shows.
	function automatic logic [255:0] mk_img();
		logic [255:0] v;
		for (int i = 0; i < 8; i++) v[32*i+:32] = {24'h5a5a5a, 8'(i)};
		return v;
	endfunction
	localparam logic [255:0] IMG = mk_img();
	// Rows: start, count, read ok, data checked. Zero and nine are bad counts.
	localparam ufb_row_t ROWS [9] = '{'{8'h00, 4'h1, 1'b1, 1'b1}, '{8'h02, 4'h4, 1'b1, 1'b1},
		'{8'h00, 4'h8, 1'b1, 1'b1}, '{8'h05, 4'h4, 1'b1, 1'b1}, '{8'h46, 4'h2, 1'b1, 1'b1},
		'{8'h64, 4'h1, 1'b0, 1'b1}, '{8'hc8, 4'h1, 1'b0, 1'b1}, '{8'h00, 4'h9, 1'b0, 1'b0},
		'{8'h00, 4'h0, 1'b0, 1'b0}};
	logic           mclk_i;
	logic           rst_i;
	logic           psel, penable, pwrite, pready, pslverr;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata, data_rdata, rd;
	logic           data_read, data_wait, data_rvalid, go, err, erased;
	logic [AW-1:0]  data_addr, m_addr;
	logic [BCW-1:0] data_burst, m_burst;
	logic [32:0]    exp_q [$]; // Bit 32 says whether the word is compared.
	int             fail_count = 0;
	int             num_checks = 0;
	int             cyc = 0;
	ufb_read_path #(.BURST_MAX(8), .INIT_LEN(8), .INIT_IMAGE(IMG)) u_dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .data_read_i(data_read),
		.data_addr_i(data_addr), .data_burst_i(data_burst), .data_wait_o(data_wait),
		.data_rvalid_o(data_rvalid), .data_rdata_o(data_rdata));
	ufb_data_master #(.AW(AW), .BCW(BCW)) u_master (
		.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .addr_i(m_addr), .burst_i(m_burst),
		.data_wait_i(data_wait), .data_read_o(data_read), .data_addr_o(data_addr),
		.data_burst_o(data_burst));
	// The flash clock ceiling binds the integrator; this model has no timing limit.
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	task automatic bad(input string m);
		fail_count++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) bad(m);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Outside the image, and once page zero is erased, every word reads as ones.
	function automatic logic [31:0] exp_word(input int a);
		if (a < 8 && !erased) return {24'h5a5a5a, 8'(a)};
		return WORD_ERASED;
	endfunction
	// One APB transfer; the request stands until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge mclk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge mclk_i);
		penable <= 1'b1;
		for (int i = 0; i < 20 && pready !== 1'b1; i++) @(posedge mclk_i);
		if (pready !== 1'b1) bad("no pready");
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic start_read(input logic [7:0] a, input logic [3:0] b, input logic c);
		int n;
		n = (b == 0) ? 1 : b;
		for (int k = 0; k < n; k++) exp_q.push_back({c, exp_word((a + k) % DEPTH)});
		@(posedge mclk_i);
		go      <= 1'b1;
		m_addr  <= a;
		m_burst <= b;
		@(posedge mclk_i);
		go <= 1'b0;
	endtask
	task automatic end_read(input logic ok);
		for (int i = 0; i < 300 && (exp_q.size() != 0 || data_read === 1'b1); i++)
			@(posedge mclk_i);
		cmp(32'(exp_q.size()), 32'h0, "missing beats");
		repeat (3) @(posedge mclk_i);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp({31'h0, rd[2]}, {31'h0, ok}, "read ok flag");
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 60; i++) begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			if (rd[1:0] === BUSY_IDLE) break;
		end
	endtask
	// Each beat is taken in order against the words owed and compared where bit 32 is set.
	always @(posedge mclk_i) begin
		if (data_rvalid === 1'b1) begin
			if (exp_q.size() == 0) bad("extra beat");
			else begin
				if (exp_q[0][32]) cmp(data_rdata, exp_q[0][31:0], "beat data");
				void'(exp_q.pop_front());
			end
		end
	end
	// A hang ends the run as a mismatch.
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad("timeout");
			results();
		end
	end
	initial begin
		rst_i = 1'b1;
		{psel, penable, pwrite, go, erased, err} = '0;
		{paddr, pwdata, m_addr, m_burst, rd} = '0;
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp(rd, 32'hffffff00, "status after reset");
		cmp(32'(data_wait), 32'h0, "stall after reset");
		apb(1'b0, ADDR_CTRL, 32'h0);
		cmp(rd, 32'hffffffff, "control after reset");
		apb(1'b1, ADDR_STATUS, 32'h0);
		cmp(32'(err), 32'h1, "status write accepted");
		apb(1'b0, 12'h008, 32'h0);
		cmp({rd[30:0], err}, 32'h1, "unmapped read");
		$display("test reset and refusals done");
		for (int i = 0; i < 9; i++) begin
			start_read(ROWS[i].addr, ROWS[i].burst, ROWS[i].chk);
			end_read(ROWS[i].ok);
			$display("test row %0d done", i);
		end
		start_read(8'h00, 4'h8, 1'b1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		cmp({30'h0, rd[1:0]}, {30'h0, BUSY_READ}, "busy during read");
		end_read(1'b1);
		$display("test busy done");
		// Protection of both user sectors is lifted before erasing page zero.
		apb(1'b1, ADDR_CTRL, 32'hfe700000);
		wait_idle();
		cmp({31'h0, rd[4]}, 32'h1, "legal erase flag");
		erased = 1'b1;
		start_read(8'h00, 4'h8, 1'b1);
		end_read(1'b1);
		apb(1'b1, ADDR_CTRL, 32'hfe7000c8);
		wait_idle();
		cmp({31'h0, rd[4]}, 32'h0, "illegal erase flag");
		apb(1'b1, ADDR_CTRL, 32'hffffffff);
		apb(1'b0, ADDR_CTRL, 32'h0);
		cmp(rd, 32'hffffffff, "protection restored");
		$display("test erase done");
		results();
	end
endmodule
